// file: src/half_step_phase_sequencer.sv
// Half-step four-phase stepper sequencer with power-up step inhibit
`timescale 1ns/1ps

// Notes on behaviour
// - Eight half-step patterns A, AB, B, BC...DA
// - Direction high clockwise, low counter-clockwise
// - Outputs advance on strobe falling edge only
// - Ignore strobe 10-30 ms after power-up
// - Position starts at state A only
// - All outputs low until first step
// - Fully static, position held indefinitely
// - Internal power-on reset, no external need
module half_step_phase_sequencer
  import stepper_seq_pkg::*;
#(
  parameter int unsigned BLOCK_CNT = BLOCK_CYCLES  // Power-up inhibit, cycles
) (
  input  wire logic i_sys_clk,  // 25 MHz system clock
  input  wire logic i_nrst,     // Async reset, active low (optional)
  input  wire logic i_step,     // Step strobe pin, asynchronous
  input  wire logic i_dir,      // Direction pin, high is clockwise
  output logic      o_phase_a,  // Winding A drive
  output logic      o_phase_b,  // Winding B drive
  output logic      o_phase_c,  // Winding C drive
  output logic      o_phase_d   // Winding D drive
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (BLOCK_CNT < 1 || BLOCK_CNT >= (1 << BLOCK_CNT_W)) begin : g_chk
    $error("BLOCK_CNT out of range");
  end

  // ----------------------------------------------------------------
  // Pattern lookup for a sequence position
  // ----------------------------------------------------------------
  function automatic phase_t pattern(input logic [POS_W-1:0] pos);
    phase_t p;
    p = PHASE_OFF;
    case (pos)
      3'h0:    p = 4'h1;
      3'h1:    p = 4'h3;
      3'h2:    p = 4'h2;
      3'h3:    p = 4'h6;
      3'h4:    p = 4'h4;
      3'h5:    p = 4'hC;
      3'h6:    p = 4'h8;
      3'h7:    p = 4'h9;
      default: p = PHASE_OFF;
    endcase
    return p;
  endfunction

  // ----------------------------------------------------------------
  // Reset release and power-on reset
  // ----------------------------------------------------------------
  // Internal power-on: reg init stands in for the supply-ramp detector
  logic [1:0] por_sr_r = 2'h0;
  logic [1:0] rst_sr_r;
  logic       rst_n;

  // Power-on shift register needs no external reset at all
  always_ff @(posedge i_sys_clk) begin
    por_sr_r <= {por_sr_r[0], 1'b1};
  end

  // External reset released through two flops
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_sr_r <= 2'h0;
    end else begin
      rst_sr_r <= {rst_sr_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sr_r[1] & por_sr_r[1];

  // ----------------------------------------------------------------
  // Input synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [1:0] step_sync_r;
  logic [1:0] dir_sync_r;
  cmd_t       cmd;
  logic       step_last_r;
  logic       dir_lat_r;
  logic       rise;
  logic       fall;

  // First stage feeds only the second stage
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_sync_r <= 2'h0;
      dir_sync_r  <= 2'h0;
    end else begin
      step_sync_r <= {step_sync_r[0], i_step};
      dir_sync_r  <= {dir_sync_r[0], i_dir};
    end
  end

  assign cmd.strobe = step_sync_r[1];
  assign cmd.cw     = dir_sync_r[1];
  assign rise       = cmd.strobe & ~step_last_r;
  assign fall       = ~cmd.strobe & step_last_r;

  // Edge history and direction capture at the rising edge
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_last_r <= 1'b0;
      dir_lat_r   <= 1'b1;
    end else begin
      step_last_r <= cmd.strobe;
      if (rise) begin
        dir_lat_r <= cmd.cw;
      end
    end
  end

  // ----------------------------------------------------------------
  // Power-up inhibit and state machine
  // ----------------------------------------------------------------
  seq_state_t             state_r;
  seq_state_t             state_nxt;
  logic [BLOCK_CNT_W-1:0] blk_cnt_r;
  logic                   blk_done;
  logic                   armed_r;
  logic                   take;

  assign blk_done = (blk_cnt_r == BLOCK_CNT_W'(BLOCK_CNT - 1));
  // A strobe already high at unblock is not a whole pulse; require a fresh rise
  assign take     = fall & armed_r & (state_r != ST_BLOCK);

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_BLOCK: if (blk_done) state_nxt = ST_IDLE;
      ST_IDLE:  if (take) state_nxt = ST_RUN;
      ST_RUN:   state_nxt = ST_RUN;
      default:  state_nxt = ST_BLOCK;
    endcase
  end

  // Inhibit counter and state register
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= ST_BLOCK;
      blk_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_BLOCK) begin
        blk_cnt_r <= blk_cnt_r + BLOCK_CNT_W'(1);
      end
    end
  end

  // Arm only on a rising edge seen after the inhibit ends
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_r <= 1'b0;
    end else if (state_r == ST_BLOCK) begin
      armed_r <= 1'b0;
    end else if (rise) begin
      armed_r <= 1'b1;
    end else if (fall) begin
      armed_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Position counter and outputs
  // ----------------------------------------------------------------
  logic [POS_W-1:0] pos_r;
  logic [POS_W-1:0] pos_nxt;
  phase_t           phase_r;
  phase_t           phase_nxt;

  // Plain 3-bit add/subtract wraps 7->0 and 0->7
  assign pos_nxt   = dir_lat_r ? pos_r + 3'h1 : pos_r - 3'h1;
  assign phase_nxt = pattern(pos_nxt);

  // Position and drive update once per accepted step
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_r   <= POS_FIRST;
      phase_r <= PHASE_OFF;
    end else if (take) begin
      pos_r   <= pos_nxt;
      phase_r <= phase_nxt;
    end
  end

  assign o_phase_a = phase_r.a;
  assign o_phase_b = phase_r.b;
  assign o_phase_c = phase_r.c;
  assign o_phase_d = phase_r.d;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [BLOCK_CNT_W-1:0] up_cnt_r;

  // Cycles since reset release, saturating
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      up_cnt_r <= '0;
    end else if (up_cnt_r != '1) begin
      up_cnt_r <= up_cnt_r + BLOCK_CNT_W'(1);
    end
  end

  property p_step_on_fall;
    @(posedge i_sys_clk) disable iff (!rst_n)
      $changed(phase_r) |-> $past(fall);
  endproperty
  a_step_on_fall: assert property (p_step_on_fall) else $error("phase moved without fall");

  property p_cw_adv;
    @(posedge i_sys_clk) disable iff (!rst_n)
      (take && dir_lat_r) |=> (pos_r == $past(pos_r) + 3'h1);
  endproperty
  a_cw_adv: assert property (p_cw_adv) else $error("cw step wrong");

  property p_ccw_back;
    @(posedge i_sys_clk) disable iff (!rst_n)
      (take && !dir_lat_r) |=> (pos_r == $past(pos_r) - 3'h1);
  endproperty
  a_ccw_back: assert property (p_ccw_back) else $error("ccw step wrong");

  property p_pattern;
    @(posedge i_sys_clk) disable iff (!rst_n)
      (state_r == ST_RUN) |-> (phase_r == pattern(pos_r));
  endproperty
  a_pattern: assert property (p_pattern) else $error("pattern mismatch");

  property p_inhibit;
    @(posedge i_sys_clk) disable iff (!rst_n)
      (up_cnt_r < BLOCK_CNT_W'(BLOCK_CNT)) |-> !take;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("step during inhibit");

  property p_off_idle;
    @(posedge i_sys_clk) disable iff (!rst_n)
      (state_r != ST_RUN) |-> (phase_r == PHASE_OFF && pos_r == POS_FIRST);
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("drive before first step");

  property p_hold;
    @(posedge i_sys_clk) disable iff (!rst_n)
      !take |=> $stable(pos_r) && $stable(phase_r);
  endproperty
  a_hold: assert property (p_hold) else $error("position drifted");

  property p_dir_latch;
    @(posedge i_sys_clk) disable iff (!rst_n)
      rise |=> (dir_lat_r == $past(cmd.cw));
  endproperty
  a_dir_latch: assert property (p_dir_latch) else $error("direction not latched");

  // A fall lags the pin by exactly two flops; one flop would be caught here
  property p_sync_delay;
    @(posedge i_sys_clk) disable iff (!rst_n)
      fall |-> !$past(i_step, 2) && $past(i_step, 3);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("edge not synchronised");

endmodule

// file: src/stepper_seq_pkg.sv
// Package of constants and types for the half-step phase sequencer
package stepper_seq_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS    = 40;
  localparam int unsigned BLOCK_NOM_MS     = 20;
  localparam int unsigned BLOCK_MIN_MS     = 10;
  localparam int unsigned BLOCK_MAX_MS     = 30;
  // Nominal inhibit in cycles, 20 ms at 25 MHz
  localparam int unsigned BLOCK_CYCLES     = BLOCK_NOM_MS * (CLK_HZ / 1000);
  localparam int unsigned BLOCK_MIN_CYCLES = BLOCK_MIN_MS * (CLK_HZ / 1000);
  localparam int unsigned BLOCK_MAX_CYCLES = BLOCK_MAX_MS * (CLK_HZ / 1000);
  localparam int unsigned BLOCK_CNT_W      = 20;
  // Far-side timing, kept for reference by the bench
  localparam int unsigned STROBE_HIGH_MIN_US = 10;
  localparam int unsigned STROBE_GAP_MIN_US  = 30;

  // ----------------------------------------------------------------
  // Sequence position and phase patterns {d, c, b, a}
  // ----------------------------------------------------------------
  localparam int unsigned POS_W     = 3;
  localparam logic [2:0]  POS_FIRST = 3'h0;
  localparam logic [2:0]  POS_LAST  = 3'h7;

  typedef struct packed {
    logic d;
    logic c;
    logic b;
    logic a;
  } phase_t;

  localparam phase_t PHASE_OFF = 4'h0;

  // Step inputs after synchronisation
  typedef struct packed {
    logic strobe;
    logic cw;
  } cmd_t;

  // Power-up state machine
  typedef enum logic [2:0] {
    ST_BLOCK = 3'b001,
    ST_IDLE  = 3'b010,
    ST_RUN   = 3'b100
  } seq_state_t;

endpackage

// file: testbench/stepper_ctrl_model.sv
// Controller model that issues step strobes and direction levels
`timescale 1ns/1ps
module stepper_ctrl_model (
  input  wire logic i_clk,   // Bench clock
  output logic      o_step,  // Step strobe to the sequencer
  output logic      o_dir    // Direction level, high is clockwise
);
  // Strobe idles low, direction starts clockwise
  initial begin
    o_step = 1'b0;
    o_dir  = 1'b1;
  end

  // Settle direction, then raise the strobe and hold it high
  task automatic rise(input logic cw, input int setup, input int high_cyc);
    @(posedge i_clk);
    o_dir <= cw;
    repeat (setup) @(posedge i_clk);
    o_step <= 1'b1;
    repeat (high_cyc) @(posedge i_clk);
  endtask

  // Lower the strobe once, then keep the gap before any next command
  task automatic fall(input int gap_cyc);
    @(posedge i_clk);
    o_step <= 1'b0;
    repeat (gap_cyc) @(posedge i_clk);
  endtask

  // Move direction while the strobe is high; must not alter that step
  task automatic set_dir(input logic cw);
    @(posedge i_clk);
    o_dir <= cw;
  endtask
endmodule

// file: testbench/tb.sv
// Self-checking bench for the half-step phase sequencer
`timescale 1ns/1ps
module tb;
  import stepper_seq_pkg::*;
  // ----------------------------------------------------------------
  // Setup
  // ----------------------------------------------------------------
  localparam int unsigned BLK = 20;   // Short inhibit keeps the run brief
  // Ten cycles of margin over the far side's minimum high time and gap
  localparam int          HI  = int'(STROBE_HIGH_MIN_US * 1000 / CLK_PERIOD_NS) + 10;
  localparam int          GAP = int'(STROBE_GAP_MIN_US * 1000 / CLK_PERIOD_NS) + 10;
  localparam phase_t PAT [8] = '{4'h1, 4'h3, 4'h2, 4'h6, 4'h4, 4'hC, 4'h8, 4'h9};
  logic   i_sys_clk = 1'b0;
  logic   i_nrst    = 1'b0;
  logic   step;
  logic   dir;
  logic   o_phase_a;
  logic   o_phase_b;
  logic   o_phase_c;
  logic   o_phase_d;
  phase_t seen;
  phase_t expected = PHASE_OFF;
  int     pos = 0;
  int     fails = 0;
  int     cmp_count = 0;
  int     cyc = 0;

  assign seen = {o_phase_d, o_phase_c, o_phase_b, o_phase_a};
  always #20 i_sys_clk = ~i_sys_clk;

  half_step_phase_sequencer #(.BLOCK_CNT(BLK)) half_step_phase_sequencer_inst (
    .i_sys_clk (i_sys_clk), .i_nrst (i_nrst), .i_step (step), .i_dir (dir),
    .o_phase_a (o_phase_a), .o_phase_b (o_phase_b),
    .o_phase_c (o_phase_c), .o_phase_d (o_phase_d));
  stepper_ctrl_model stepper_ctrl_model_inst (.i_clk (i_sys_clk), .o_step (step), .o_dir (dir));

  // Hang guard, well above the roughly 25k cycles of the sequence
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input phase_t got, input phase_t exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: phases %h expected %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset, outputs all off while the position sits at state one
  task automatic do_reset();
    @(posedge i_sys_clk);
    i_nrst <= 1'b0;
    repeat (8) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    pos = 0;
    expected = PHASE_OFF;
    @(negedge i_sys_clk) check(seen, PHASE_OFF);
  endtask

  // One full step; nothing may move while the strobe is only high
  task automatic step_and_check(input logic cw);
    stepper_ctrl_model_inst.rise(cw, 60, HI);
    @(negedge i_sys_clk) check(seen, expected);
    stepper_ctrl_model_inst.fall(GAP);
    pos = cw ? (pos + 1) % 8 : (pos + 7) % 8;
    expected = PAT[pos];
    @(negedge i_sys_clk) check(seen, expected);
  endtask

  // A strobe inside the inhibit window is refused
  task automatic test_inhibit();
    do_reset();
    stepper_ctrl_model_inst.rise(1'b1, 1, 4);
    stepper_ctrl_model_inst.fall(40);
    @(negedge i_sys_clk) check(seen, PHASE_OFF);
  endtask

  // Direction flipped after the rise keeps the step clockwise
  task automatic test_dir_hold();
    stepper_ctrl_model_inst.rise(1'b1, 60, 20);
    stepper_ctrl_model_inst.set_dir(1'b0);
    repeat (HI) @(posedge i_sys_clk);
    stepper_ctrl_model_inst.fall(GAP);
    pos = (pos + 1) % 8;
    expected = PAT[pos];
    @(negedge i_sys_clk) check(seen, expected);
  endtask

  // Position held through a long quiet stretch
  task automatic test_static();
    repeat (2000) @(posedge i_sys_clk);
    @(negedge i_sys_clk) check(seen, expected);
  endtask

  // Second reset mid-run: first counter-clockwise step lands on D and A
  task automatic test_rereset();
    do_reset();
    repeat (30) @(posedge i_sys_clk);
    step_and_check(1'b0);
  endtask

  initial begin
    test_inhibit();
    repeat (9) step_and_check(1'b1);
    repeat (10) step_and_check(1'b0);
    test_dir_hold();
    test_static();
    test_rereset();
    tally_and_finish();
  end
endmodule
